// >>> hdl/adsrc_pkg.sv
// constants, field layout and state types of the converter serial and rate control block
//
// Functional notes
// - writes on serial input, reads on output
// - all bits timed by external serial clock
// - ready low when new word loaded
// - ready high after data register read completes
// - ready high before data register update
// - three-wire use with chip select tied low
// - ready mirrored in mode register bit seven
// - settling one, two, three output periods
// - auto mode steps fast, sinc2, sinc3
// - decimation accepted only from 20 to 2047
// - modulator rate is oscillator over 128/256
// - sampling rate multiplied by 2, 4, 8 at gains 16, 32, 64 and 128
// - one output word per decimation count
// - signed output codes follow input sign
// - chip select high: ignore bus, stay inactive
// - polarity pin inverts serial clock only
// - back to back burst transfers allowed
package adsrc_pkg;
	localparam int WORD_W = 24;
	localparam int DEC_W  = 11;
	localparam int FIFO_DEPTH = 4;

	typedef enum logic [1:0] {FLT_AUTO, FLT_FAST, FLT_SINC2, FLT_SINC3} adsrc_flt_t;
	typedef enum logic [1:0] {SER_CMD, SER_RDATA, SER_RREG, SER_WREG} adsrc_ser_t;
	typedef enum logic [1:0] {UPD_IDLE, UPD_RAISE} adsrc_upd_t;

	// command byte: read data, or high nibble opcode with register index in low nibble
	localparam logic [7:0] CMD_RDATA = 8'h01;
	localparam logic [3:0] OP_RREG   = 4'h1;
	localparam logic [3:0] OP_WREG   = 4'h5;

	localparam logic [3:0] REG_CFG           = 4'h0;
	localparam logic [3:0] REG_MODE_DEC_HIGH = 4'h1;
	localparam logic [3:0] REG_DEC_LOW       = 4'h2;

	localparam int CFG_FLT_LSB   = 0;
	localparam int CFG_SPEED_BIT = 2;
	localparam int CFG_GAIN_LSB  = 3;
	localparam int MDH_READY_BIT = 7;
	localparam int MDH_DEC_W     = 3;

	localparam logic [7:0]       CFG_RESET = 8'h00;
	localparam logic [DEC_W-1:0] DEC_RESET = 11'h080;
	localparam logic [DEC_W-1:0] DEC_MIN   = 11'h014;
	localparam logic [DEC_W-1:0] DEC_MAX   = 11'h7FF;

	localparam logic [DEC_W-1:0] MFACTOR_SLOW = 11'h080;
	localparam logic [DEC_W-1:0] MFACTOR_FAST = 11'h100;

	localparam logic [1:0] SETTLE_FAST  = 2'h1;
	localparam logic [1:0] SETTLE_SINC2 = 2'h2;
	localparam logic [1:0] SETTLE_SINC3 = 2'h3;

	localparam logic [4:0] CMD_LAST_BIT  = 5'h07;
	localparam logic [4:0] DATA_LAST_BIT = 5'h17;
endpackage : adsrc_pkg

// >>> hdl/adsrc_stream_if.sv
// valid/ready word stream between the block's own modules
interface adsrc_stream_if #(parameter int W = 24);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : adsrc_stream_if

// >>> hdl/adsrc_div.sv
// restartable tick divider for the oscillator derived rates
module adsrc_div #(
	parameter int W = 11
) (
	input  wire logic         clk_i,     // block clock
	input  wire logic         srst_i,    // sync reset, high
	input  wire logic         ce_i,      // clock enable
	input  wire logic         tick_i,    // one count step
	input  wire logic         restart_i, // clear count
	input  wire logic [W-1:0] period_i,  // steps per pulse
	output logic              pulse_o    // one cycle per period
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         pulse;
	} adsrc_div_st_t;

	adsrc_div_st_t st_q;
	adsrc_div_st_t st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.pulse = 1'b0;
		if (restart_i)
			st_d.cnt = '0;
		else if (tick_i)
		begin
			if (st_q.cnt >= period_i - W'(1))
			begin
				st_d.cnt = '0;
				st_d.pulse = 1'b1;
			end
			else
				st_d.cnt = st_q.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			st_q <= '0;
		else if (ce_i)
			st_q <= st_d;
	end

	assign pulse_o = st_q.pulse;
endmodule : adsrc_div

// >>> hdl/adsrc_fifo.sv
// small word fifo ahead of the data output register
module adsrc_fifo #(
	parameter int W     = 24,
	parameter int DEPTH = 4
) (
	input  wire logic   clk_i,  // block clock
	input  wire logic   srst_i, // sync reset, high
	input  wire logic   ce_i,   // clock enable
	adsrc_stream_if.snk wr,     // filling side
	adsrc_stream_if.src rd      // draining side
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wptr;
		logic [AW-1:0]           rptr;
		logic [AW:0]             cnt;
		logic                    in_rdy;
	} adsrc_fifo_st_t;

	adsrc_fifo_st_t st_q;
	adsrc_fifo_st_t st_d;
	logic           push;
	logic           pop;

	assign push = wr.valid && st_q.in_rdy;
	assign pop  = rd.ready && (st_q.cnt != '0);

	always_comb
	begin
		st_d = st_q;
		if (push)
		begin
			st_d.mem[st_q.wptr] = wr.data;
			st_d.wptr = (st_q.wptr == AW'(DEPTH - 1)) ? '0 : st_q.wptr + AW'(1);
		end
		if (pop)
			st_d.rptr = (st_q.rptr == AW'(DEPTH - 1)) ? '0 : st_q.rptr + AW'(1);
		st_d.cnt = st_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		// ready is registered from the next count so the filling side sees a flop, with no slot lost
		st_d.in_rdy = st_d.cnt < (AW + 1)'(DEPTH);
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st_q <= '0;
			st_q.in_rdy <= 1'b1;
		end
		else if (ce_i)
			st_q <= st_d;
	end

	assign wr.ready = st_q.in_rdy;
	assign rd.valid = st_q.cnt != '0;
	assign rd.data  = st_q.mem[st_q.rptr];
endmodule : adsrc_fifo

// >>> hdl/adsrc_ctrl.sv
// serial register port, conversion-ready flag, rate dividers and filter stepping
module adsrc_ctrl (
	input  wire logic                        clk_i,                 // block clock, 10 MHz
	input  wire logic                        srst_i,                // sync reset, high
	input  wire logic                        ce_i,                  // clock enable
	input  wire logic                        osc_i,                 // oscillator pin
	input  wire logic                        cs_n_i,                // chip select pin, low
	input  wire logic                        sclk_i,                // serial clock pin
	input  wire logic                        din_i,                 // serial data in pin
	input  wire logic                        clock_polarity_select_i, // serial clock polarity pin
	input  wire logic [2:0]                  channel_i,             // selected input channel
	input  wire logic [adsrc_pkg::WORD_W-1:0] word_i,               // filtered signed word
	input  wire logic                        word_valid_i,          // word offered
	output logic                             word_ready_o,          // word taken
	output logic                             dout_o,                // serial data out
	output logic                             dout_oe_o,             // serial out driven
	output logic                             conversion_ready_n_o,  // ready flag, low
	output logic                             mod_tick_o,            // modulator rate pulse
	output logic                             samp_tick_o,           // sampling rate pulse
	output logic                             data_tick_o,           // output rate pulse
	output logic [1:0]                       active_filter_o,       // filter in use
	output logic                             settled_o              // output settled
);
	localparam int WW = adsrc_pkg::WORD_W;
	localparam int DW = adsrc_pkg::DEC_W;

	typedef struct packed {
		logic [2:0]              osc_s;
		logic [1:0]              sclk_s;
		logic [1:0]              cs_s;
		logic [1:0]              din_s;
		logic [1:0]              pol_s;
		logic                    eff_prev;
		adsrc_pkg::adsrc_ser_t   ser;
		logic [4:0]              bitcnt;
		logic [7:0]              rx;
		logic [WW-1:0]           tx;
		logic [3:0]              ridx;
		logic                    dout;
		logic                    oe;
		logic [7:0]              cfg;
		logic [DW-1:0]           dec;
		logic                    restart;
		logic signed [WW-1:0]    data_output_register;
		logic                    rdy_n;
		adsrc_pkg::adsrc_upd_t   upd;
		logic                    pending;
		logic                    pop;
		logic [2:0]              chan_prev;
		adsrc_pkg::adsrc_flt_t   flt;
		logic [1:0]              periods;
		logic                    settled;
	} adsrc_ctrl_st_t;

	adsrc_ctrl_st_t st_q;
	adsrc_ctrl_st_t st_d;

	adsrc_stream_if #(.W(WW)) in_if ();
	adsrc_stream_if #(.W(WW)) out_if ();

	logic          osc_edge;
	logic [DW-1:0] mfactor;
	logic [DW-1:0] samp_period;
	logic [2:0]    gain_code;
	logic          mod_pulse;
	logic          samp_pulse;
	logic          data_pulse;

	function automatic logic [1:0] settle_need(input adsrc_pkg::adsrc_flt_t f);
		case (f)
			adsrc_pkg::FLT_FAST:  settle_need = adsrc_pkg::SETTLE_FAST;
			adsrc_pkg::FLT_SINC2: settle_need = adsrc_pkg::SETTLE_SINC2;
			default:              settle_need = adsrc_pkg::SETTLE_SINC3;
		endcase
	endfunction : settle_need

	assign in_if.valid = word_valid_i;
	assign in_if.data  = word_i;
	assign out_if.ready = st_q.pop;

	adsrc_fifo #(
		.W     (WW),
		.DEPTH (adsrc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.ce_i   (ce_i),
		.wr     (in_if.snk),
		.rd     (out_if.src)
	);

	assign osc_edge  = st_q.osc_s[1] && !st_q.osc_s[2];
	assign gain_code = st_q.cfg[adsrc_pkg::CFG_GAIN_LSB +: 3];
	assign mfactor   = st_q.cfg[adsrc_pkg::CFG_SPEED_BIT] ? adsrc_pkg::MFACTOR_FAST
		: adsrc_pkg::MFACTOR_SLOW;

	always_comb
	begin
		// gains 1..8 sample at the modulator rate, 16 at x2, 32 at x4, 64 and 128 at x8
		case (gain_code)
			3'h4:       samp_period = mfactor >> 1;
			3'h5:       samp_period = mfactor >> 2;
			3'h6, 3'h7: samp_period = mfactor >> 3;
			default:    samp_period = mfactor;
		endcase
	end

	adsrc_div #(.W(DW)) u_samp_div (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.ce_i      (ce_i),
		.tick_i    (osc_edge),
		.restart_i (st_q.restart),
		.period_i  (samp_period),
		.pulse_o   (samp_pulse)
	);

	adsrc_div #(.W(DW)) u_mod_div (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.ce_i      (ce_i),
		.tick_i    (osc_edge),
		.restart_i (st_q.restart),
		.period_i  (mfactor),
		.pulse_o   (mod_pulse)
	);

	adsrc_div #(.W(DW)) u_data_div (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.ce_i      (ce_i),
		.tick_i    (mod_pulse),
		.restart_i (st_q.restart),
		.period_i  (st_q.dec),
		.pulse_o   (data_pulse)
	);

	always_comb
	begin
		logic          eff;
		logic          cap;
		logic          launch;
		logic [7:0]    rx_new;
		logic [DW-1:0] dec_new;
		logic [1:0]    p_next;
		logic          reading;

		st_d = st_q;
		eff = 1'b0;
		cap = 1'b0;
		launch = 1'b0;
		rx_new = '0;
		dec_new = st_q.dec;
		p_next = '0;
		reading = 1'b0;

		st_d.osc_s = {st_q.osc_s[1:0], osc_i};
		st_d.sclk_s = {st_q.sclk_s[0], sclk_i};
		st_d.cs_s = {st_q.cs_s[0], cs_n_i};
		st_d.din_s = {st_q.din_s[0], din_i};
		st_d.pol_s = {st_q.pol_s[0], clock_polarity_select_i};
		st_d.restart = 1'b0;
		st_d.pop = 1'b0;

		// polarity only flips which level counts as active, the framing is unchanged
		eff = st_q.sclk_s[1] ^ st_q.pol_s[1];
		st_d.eff_prev = eff;
		cap = eff && !st_q.eff_prev;
		launch = !eff && st_q.eff_prev;
		rx_new = {st_q.rx[6:0], st_q.din_s[1]};

		if (st_q.cs_s[1])
		begin
			st_d.ser = adsrc_pkg::SER_CMD;
			st_d.bitcnt = '0;
			st_d.oe = 1'b0;
			st_d.dout = 1'b0;
		end
		else
		begin
			// cs tied low keeps this branch live, so framing rests on bit counts alone
			st_d.oe = 1'b1;
			if (cap)
			begin
				st_d.rx = rx_new;
				st_d.bitcnt = st_q.bitcnt + 5'h01;
				case (st_q.ser)
					adsrc_pkg::SER_CMD:
					begin
						if (st_q.bitcnt == adsrc_pkg::CMD_LAST_BIT)
						begin
							st_d.bitcnt = '0;
							st_d.ridx = rx_new[3:0];
							if (rx_new == adsrc_pkg::CMD_RDATA)
							begin
								st_d.ser = adsrc_pkg::SER_RDATA;
								st_d.tx = st_q.data_output_register;
							end
							else if (rx_new[7:4] == adsrc_pkg::OP_RREG)
							begin
								st_d.ser = adsrc_pkg::SER_RREG;
								case (rx_new[3:0])
									adsrc_pkg::REG_CFG:
										st_d.tx = {st_q.cfg, 16'h0000};
									adsrc_pkg::REG_MODE_DEC_HIGH:
										st_d.tx = {st_q.rdy_n, 4'h0, st_q.dec[DW-1 -: adsrc_pkg::MDH_DEC_W],
											16'h0000};
									adsrc_pkg::REG_DEC_LOW:
										st_d.tx = {st_q.dec[7:0], 16'h0000};
									default:
										st_d.tx = '0;
								endcase
							end
							else if (rx_new[7:4] == adsrc_pkg::OP_WREG)
								st_d.ser = adsrc_pkg::SER_WREG;
						end
					end
					adsrc_pkg::SER_RDATA:
					begin
						if (st_q.bitcnt == adsrc_pkg::DATA_LAST_BIT)
						begin
							st_d.ser = adsrc_pkg::SER_CMD;
							st_d.bitcnt = '0;
							st_d.rdy_n = 1'b1;
						end
					end
					adsrc_pkg::SER_RREG:
					begin
						if (st_q.bitcnt == adsrc_pkg::CMD_LAST_BIT)
						begin
							st_d.ser = adsrc_pkg::SER_CMD;
							st_d.bitcnt = '0;
						end
					end
					adsrc_pkg::SER_WREG:
					begin
						if (st_q.bitcnt == adsrc_pkg::CMD_LAST_BIT)
						begin
							st_d.ser = adsrc_pkg::SER_CMD;
							st_d.bitcnt = '0;
							case (st_q.ridx)
								adsrc_pkg::REG_CFG:
								begin
									st_d.cfg = rx_new;
									st_d.restart = rx_new != st_q.cfg;
									st_d.periods = '0;
									st_d.settled = 1'b0;
									st_d.flt = (rx_new[1:0] == 2'h0) ? adsrc_pkg::FLT_FAST
										: adsrc_pkg::adsrc_flt_t'(rx_new[1:0]);
								end
								adsrc_pkg::REG_MODE_DEC_HIGH:
									dec_new = {rx_new[adsrc_pkg::MDH_DEC_W-1:0], st_q.dec[7:0]};
								adsrc_pkg::REG_DEC_LOW:
									dec_new = {st_q.dec[DW-1 -: adsrc_pkg::MDH_DEC_W], rx_new};
								default:
									dec_new = st_q.dec;
							endcase
							// a ratio outside the range leaves the old one in force
							if (dec_new >= adsrc_pkg::DEC_MIN && dec_new <= adsrc_pkg::DEC_MAX
								&& dec_new != st_q.dec)
							begin
								st_d.dec = dec_new;
								st_d.restart = 1'b1;
							end
						end
					end
					default:
						st_d.ser = adsrc_pkg::SER_CMD;
				endcase
			end
			else if (launch)
			begin
				if (st_q.ser == adsrc_pkg::SER_RDATA || st_q.ser == adsrc_pkg::SER_RREG)
				begin
					st_d.dout = st_q.tx[WW-1];
					st_d.tx = {st_q.tx[WW-2:0], 1'b0};
				end
				else
					st_d.dout = 1'b0;
			end
		end

		// an update never lands under a data read in progress
		reading = !st_q.cs_s[1] && (st_q.ser == adsrc_pkg::SER_RDATA || st_d.ser == adsrc_pkg::SER_RDATA);
		if (data_pulse)
			st_d.pending = 1'b1;
		case (st_q.upd)
			adsrc_pkg::UPD_IDLE:
			begin
				if (st_q.pending && out_if.valid && !st_q.pop && !reading)
				begin
					st_d.rdy_n = 1'b1;
					st_d.upd = adsrc_pkg::UPD_RAISE;
				end
			end
			adsrc_pkg::UPD_RAISE:
			begin
				st_d.data_output_register = out_if.data;
				st_d.pop = 1'b1;
				// a read starting in this cycle must shift out the word being loaded
				if (st_q.ser == adsrc_pkg::SER_CMD && st_d.ser == adsrc_pkg::SER_RDATA)
					st_d.tx = out_if.data;
				st_d.rdy_n = 1'b0;
				st_d.pending = data_pulse;
				st_d.upd = adsrc_pkg::UPD_IDLE;
			end
			default:
				st_d.upd = adsrc_pkg::UPD_IDLE;
		endcase

		st_d.chan_prev = channel_i;
		if (channel_i != st_q.chan_prev)
		begin
			st_d.periods = '0;
			st_d.settled = 1'b0;
			if (st_q.cfg[1:0] == 2'h0)
				st_d.flt = adsrc_pkg::FLT_FAST;
		end
		else if (data_pulse)
		begin
			p_next = (st_q.periods == 2'h3) ? st_q.periods : st_q.periods + 2'h1;
			st_d.periods = p_next;
			if (p_next >= settle_need(st_q.flt))
			begin
				st_d.settled = 1'b1;
				if (st_q.cfg[1:0] == 2'h0 && st_q.flt != adsrc_pkg::FLT_SINC3)
				begin
					// each stage starts its own settling count after the step
					st_d.flt = (st_q.flt == adsrc_pkg::FLT_FAST) ? adsrc_pkg::FLT_SINC2
						: adsrc_pkg::FLT_SINC3;
					st_d.periods = '0;
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st_q <= '0;
			st_q.cfg <= adsrc_pkg::CFG_RESET;
			st_q.dec <= adsrc_pkg::DEC_RESET;
			st_q.rdy_n <= 1'b1;
			st_q.cs_s <= 2'b11;
			st_q.ser <= adsrc_pkg::SER_CMD;
			st_q.upd <= adsrc_pkg::UPD_IDLE;
			st_q.flt <= adsrc_pkg::FLT_FAST;
		end
		else if (ce_i)
			st_q <= st_d;
	end

	assign word_ready_o         = in_if.ready;
	assign dout_o               = st_q.dout;
	assign dout_oe_o            = st_q.oe;
	assign conversion_ready_n_o = st_q.rdy_n;
	assign mod_tick_o           = mod_pulse;
	assign samp_tick_o          = samp_pulse;
	assign data_tick_o          = data_pulse;
	assign active_filter_o      = st_q.flt;
	assign settled_o            = st_q.settled;
endmodule : adsrc_ctrl

// >>> sim/adsrc_master.sv
// serial bus master model for the converter's register port
module adsrc_master (
	input  wire logic clk_i,  // bench clock
	input  wire logic dout_i, // device serial out
	input  wire logic oe_i,   // device drives serial out
	input  wire logic pol_i,  // polarity pin level
	output logic      cs_n_o, // chip select, low
	output logic      sclk_o, // serial clock
	output logic      din_o   // serial data to device
);
	timeunit 1ns;
	timeprecision 1ns;
	logic e = 1'b0;
	// serial clock stands still between frames
	assign sclk_o = e ^ pol_i;
	initial
	begin
		cs_n_o = 1'b1;
		din_o  = 1'b0;
	end
	// msb first; sel low leaves the device deselected, keep holds select for three-wire use
	task automatic xfer(input int n, input logic [31:0] tx, input bit sel, input bit keep, output logic [31:0] rx);
		@(negedge clk_i);
		rx     = '0;
		cs_n_o = !sel;
		repeat (4) @(negedge clk_i);
		for (int i = n - 1; i >= 0; i--)
		begin
			din_o = tx[i];
			repeat (4) @(negedge clk_i);
			rx[i] = oe_i ? dout_i : 1'bx;
			e     = 1'b1;
			repeat (4) @(negedge clk_i);
			e = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		// a released data line must not keep its last level
		din_o  = ~din_o;
		cs_n_o = !(sel && keep);
	endtask : xfer
endmodule : adsrc_master

// >>> sim/adsrc_ctrl_asserts.sv
// concurrent checks on the converter control block's ports
module adsrc_ctrl_asserts (
	input wire logic       clk_i,                // block clock
	input wire logic       srst_i,               // sync reset
	input wire logic       ce_i,                 // clock enable
	input wire logic       osc_i,                // oscillator pin
	input wire logic       cs_n_i,               // chip select, low
	input wire logic       word_ready_o,         // fifo not full
	input wire logic       dout_oe_o,            // serial out driven
	input wire logic       conversion_ready_n_o, // ready flag, low
	input wire logic       mod_tick_o,           // modulator pulse
	input wire logic       data_tick_o,          // output rate pulse
	input wire logic [1:0] active_filter_o,      // filter in use
	input wire logic       settled_o             // output settled
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       osc_q;
	logic       seen_q;
	logic [9:0] edges_q;
	logic [5:0] mods_q;
	wire        rise = osc_i && !osc_q;
	always_ff @(posedge clk_i)
	begin
		osc_q <= osc_i;
		if (srst_i)
		begin
			seen_q  <= 1'b0;
			edges_q <= 10'h000;
			mods_q  <= 6'h00;
		end
		else
		begin
			if (mod_tick_o)
				seen_q <= 1'b1;
			if (mod_tick_o)
				edges_q <= {9'h000, rise};
			else if (rise && edges_q != 10'h3FF)
				edges_q <= edges_q + 10'h001;
			if (data_tick_o)
				mods_q <= 6'h00;
			else if (mod_tick_o && mods_q != 6'h3F)
				mods_q <= mods_q + 6'h01;
		end
	end
	a_cs_idle_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
		(cs_n_i && ce_i) [*4] |-> !dout_oe_o) else $error("serial out driven while deselected");
	a_oe_after_cs: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(dout_oe_o) |-> !$past(cs_n_i, 2)) else $error("serial out driven without select");
	a_reset_state: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) |-> conversion_ready_n_o && word_ready_o && active_filter_o == 2'h1 && !settled_o)
		else $error("wrong state after reset");
	a_filter_code: assert property (@(posedge clk_i) disable iff (srst_i)
		active_filter_o != 2'h0) else $error("filter code out of range");
	a_load_frees_slot: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(conversion_ready_n_o) && ce_i |=> word_ready_o) else $error("loaded word not taken from fifo");
	// sync lag can move one edge across a divider restart
	a_mod_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
		mod_tick_o && seen_q |-> edges_q >= 10'd127) else $error("modulator pulse too early");
	a_data_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
		data_tick_o |-> ({1'b0, mods_q} + {6'h00, mod_tick_o}) >= 7'd20) else $error("output pulse too early");
	a_settle_tick: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(settled_o) |-> $past(data_tick_o, 1) || $past(data_tick_o, 2) || $past(data_tick_o, 3))
		else $error("settled without output period");
endmodule : adsrc_ctrl_asserts

bind adsrc_ctrl adsrc_ctrl_asserts adsrc_ctrl_asserts_i (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
	.osc_i(osc_i), .cs_n_i(cs_n_i), .word_ready_o(word_ready_o), .dout_oe_o(dout_oe_o),
	.conversion_ready_n_o(conversion_ready_n_o), .mod_tick_o(mod_tick_o), .data_tick_o(data_tick_o),
	.active_filter_o(active_filter_o), .settled_o(settled_o));

// >>> sim/test_adsrc_ctrl.sv
// self-checking bench of the converter serial port, ready flag and rate dividers
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin err_total++; $display("wrong value at %0t ns: %s", $time, m); end end
module test_adsrc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk    = 1'b0;
	logic        srst   = 1'b1;
	logic        osc    = 1'b0;
	logic        clock_polarity_select    = 1'b0;
	logic        ce     = 1'b1;
	logic [1:0]  ph     = 2'h0;
	logic [2:0]  chan   = 3'h0;
	logic [23:0] word   = 24'h00_0000;
	logic        wvalid = 1'b0;
	logic [31:0] seed   = 32'hd9b3_8d80;
	logic [31:0] rx;
	logic [7:0]  v;
	logic [2:0]  g;
	logic        sp;
	logic        acc;
	logic [23:0] q[$];
	int          err_total = 0;
	int          compares  = 0;
	int          cyc       = 0;
	int          nc, nm, ns;
	wire         cs_n, sclk, din, wready, dout, oe, rdy_n, mtick, stick, dtick, settled;
	wire  [1:0]  filt;
	adsrc_ctrl adsrc_ctrl_i (.clk_i(clk), .srst_i(srst), .ce_i(ce), .osc_i(osc), .cs_n_i(cs_n), .sclk_i(sclk),
		.din_i(din), .clock_polarity_select_i(clock_polarity_select), .channel_i(chan), .word_i(word), .word_valid_i(wvalid),
		.word_ready_o(wready), .dout_o(dout), .dout_oe_o(oe), .conversion_ready_n_o(rdy_n), .mod_tick_o(mtick),
		.samp_tick_o(stick), .data_tick_o(dtick), .active_filter_o(filt), .settled_o(settled));
	adsrc_master adsrc_master_i (.clk_i(clk), .dout_i(dout), .oe_i(oe), .pol_i(clock_polarity_select), .cs_n_o(cs_n), .sclk_o(sclk),
		.din_o(din));
	initial
	begin
		forever #50 clk = ~clk;
	end
	// oscillator at four clock periods, the fastest the synchronisers can follow
	always @(negedge clk)
	begin
		ph  <= ph + 2'h1;
		osc <= ph[1];
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			err_total++;
			end_sim();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic int samp_mult(input logic [2:0] gc);
		return (gc < 3'h4) ? 1 : (gc == 3'h4) ? 2 : (gc == 3'h5) ? 4 : 8;
	endfunction : samp_mult
	task automatic rd_reg(input logic [3:0] r, input bit keep, output logic [7:0] d);
		adsrc_master_i.xfer(16, {16'h0000, adsrc_pkg::OP_RREG, r, 8'h00}, 1'b1, keep, rx);
		d = rx[7:0];
	endtask : rd_reg
	task automatic wr_reg(input logic [3:0] r, input logic [7:0] d, input bit sel);
		adsrc_master_i.xfer(16, {16'h0000, adsrc_pkg::OP_WREG, r, d}, sel, 1'b0, rx);
	endtask : wr_reg
	task automatic rd_data();
		adsrc_master_i.xfer(32, {adsrc_pkg::CMD_RDATA, 24'h00_0000}, 1'b1, 1'b1, rx);
		repeat (4) @(negedge clk);
		`CHK(rx[23:0], q.pop_front(), "data word")
		`CHK(rdy_n, 1'b1, "flag after read")
	endtask : rd_data
	// counts cycles and ticks up to and including the next chosen pulse
	task automatic wait_tick(input bit data, output int n, output int m, output int s);
		n = 0;
		m = 0;
		s = 0;
		do
		begin
			@(negedge clk);
			n++;
			m += int'(mtick);
			s += int'(stick);
		end
		while (!(data ? dtick : mtick) && n < 30000);
	endtask : wait_tick
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (10) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		`CHK(rdy_n, 1'b1, "flag after reset")
		`CHK(filt, 2'h1, "filter after reset")
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			clock_polarity_select = i[0];
			rd_reg(i[3:0], 1'b0, v);
			`CHK(v, (i == 1 || i == 2) ? 8'h80 : 8'h00, "register after reset")
		end
		$display("test registers done");
		wr_reg(adsrc_pkg::REG_CFG, 8'h04, 1'b0);
		adsrc_master_i.xfer(4, 32'h0000_0005, 1'b1, 1'b0, rx);
		rd_reg(adsrc_pkg::REG_CFG, 1'b0, v);
		`CHK(v, 8'h00, "write while deselected")
		wr_reg(adsrc_pkg::REG_DEC_LOW, 8'h13, 1'b1);
		rd_reg(adsrc_pkg::REG_DEC_LOW, 1'b0, v);
		`CHK(v, 8'h80, "ratio below range")
		wr_reg(adsrc_pkg::REG_DEC_LOW, 8'hFF, 1'b1);
		wr_reg(adsrc_pkg::REG_MODE_DEC_HIGH, 8'h07, 1'b1);
		rd_reg(adsrc_pkg::REG_MODE_DEC_HIGH, 1'b0, v);
		`CHK(v, 8'h87, "ratio at top of range")
		wr_reg(adsrc_pkg::REG_MODE_DEC_HIGH, 8'h00, 1'b1);
		wr_reg(adsrc_pkg::REG_DEC_LOW, 8'h14, 1'b1);
		rd_reg(adsrc_pkg::REG_DEC_LOW, 1'b0, v);
		`CHK(v, 8'h14, "ratio at bottom of range")
		$display("test ratio done");
		for (int k = 0; k < 10; k++)
		begin
			seed = lfsr(seed);
			g    = (k < 8) ? k[2:0] : seed[2:0];
			sp   = (k >= 8);
			wr_reg(adsrc_pkg::REG_CFG, {2'b00, g, sp, k[1:0]}, 1'b1);
			wait_tick(1'b0, nc, nm, ns);
			wait_tick(1'b0, nc, nm, ns);
			`CHK(nc, (sp ? 256 : 128) * 4, "modulator period")
			`CHK(ns, samp_mult(g), "sampling pulses per period")
			if (k[1:0] != 2'b00)
				`CHK(filt, k[1:0], "fixed filter")
		end
		wr_reg(adsrc_pkg::REG_CFG, 8'h00, 1'b1);
		wait_tick(1'b1, nc, nm, ns);
		wait_tick(1'b1, nc, nm, ns);
		`CHK(nm, 20, "modulator pulses per word")
		$display("test rates done");
		acc = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			if (acc)
			begin
				seed = lfsr(seed);
				word = (i == 0) ? 24'h80_0000 : (i == 1) ? 24'h7F_FFFF : seed[23:0];
			end
			wvalid = 1'b1;
			acc = wready;
			if (acc)
				q.push_back(word);
			@(negedge clk);
		end
		wvalid = 1'b0;
		`CHK(q.size(), 5, "words taken until full")
		`CHK(rdy_n, 1'b0, "flag with word loaded")
		seed = lfsr(seed);
		chan = chan + 3'h1 + {1'b0, seed[1:0]};
		repeat (3) @(negedge clk);
		`CHK(filt, 2'h1, "fast filter after channel change")
		`CHK(settled, 1'b0, "unsettled after channel change")
		rd_data();
		for (int t = 0; t < 4; t++)
		begin
			wait_tick(1'b1, nc, nm, ns);
			repeat (4) @(negedge clk);
			`CHK(filt, (t < 2) ? 2'h2 : 2'h3, "auto filter step")
			`CHK(settled, 1'b1, "settled after first period")
			`CHK(rdy_n, 1'b0, "flag after update")
			rd_reg(adsrc_pkg::REG_MODE_DEC_HIGH, 1'b1, v);
			`CHK(v[7], 1'b0, "flag mirrored in register")
			rd_data();
		end
		`CHK(wready, 1'b1, "fifo drained")
		$display("test words done");
		wait_tick(1'b0, nc, nm, ns);
		@(negedge clk);
		ce = 1'b0;
		nm = 0;
		repeat (600)
		begin
			@(negedge clk);
			nm += int'(mtick);
		end
		ce = 1'b1;
		`CHK(nm, 0, "modulator ticks while frozen")
		wait_tick(1'b0, nc, nm, ns);
		wait_tick(1'b0, nc, nm, ns);
		`CHK(nc, 512, "modulator period after freeze")
		$display("test freeze done");
		end_sim();
	end
endmodule : test_adsrc_ctrl
